//--- ssm_monitor_ctrl.v
`timescale 1ns/10ps
`include "ssm_defines.vh"

module ssm_monitor_ctrl (
  clk,
  sys_rst,
  reg_bank,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  phase_wakeup,
  phase_preamble,
  phase_data,
  wakeup_start,
  preamble_start,
  status_read,
  bit_tick,
  mon_pass,
  mon_fail,
  coding_rule,
  mon_enable,
  wakeup_pass,
  wakeup_fail,
  preamble_timeout,
  error_flags
);
  input wire clk;
  input wire sys_rst;
  input wire [1:0] reg_bank;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  input wire phase_wakeup;
  input wire phase_preamble;
  input wire phase_data;
  input wire wakeup_start;
  input wire preamble_start;
  input wire status_read;
  input wire bit_tick;
  input wire [5:0] mon_pass;
  input wire [5:0] mon_fail;
  output reg [1:0] coding_rule;
  output reg [5:0] mon_enable;
  output reg wakeup_pass;
  output reg wakeup_fail;
  output reg preamble_timeout;
  output reg [5:0] error_flags;

  localparam ST_IDLE = 1'b0;
  localparam ST_SEARCH = 1'b1;

  reg [7:0] data_phase_rx_control_reg;
  reg [7:0] wakeup_monitor_control_reg;
  reg [7:0] preamble_monitor_control_reg;
  reg [7:0] wakeup_timeout_register_reg;
  reg state_reg;
  reg [5:0] passed_reg;
  reg pre_active_reg;

  wire bank_ok;
  wire [1:0] wakeup_coding_rule;
  wire preamble_coding_rule;
  wire data_coding_rule;
  wire wakeup_search_policy;
  wire [5:0] wakeup_monitor_select;
  wire [5:0] preamble_monitor_select;
  wire preamble_timeout_enable;
  wire preamble_error_accumulate;
  wire [5:0] wake_fail;
  wire [5:0] passed_next;
  wire all_passed;
  wire any_failed;
  wire [5:0] pre_fail;
  wire timer_restart;
  wire timer_run;
  wire timer_expired;

  reg [1:0] coding_next;
  reg [5:0] enable_next;
  reg [7:0] rdata_next;

  assign bank_ok = (reg_bank == `SSM_BANK_MON);

  assign wakeup_coding_rule =
    data_phase_rx_control_reg[`SSM_WAKE_CODE_HI:`SSM_WAKE_CODE_LO];
  assign preamble_coding_rule =
    data_phase_rx_control_reg[`SSM_PRE_CODE_BIT];
  assign data_coding_rule = data_phase_rx_control_reg[`SSM_DATA_CODE_BIT];
  assign wakeup_search_policy = wakeup_monitor_control_reg[`SSM_POLICY_BIT];
  assign wakeup_monitor_select =
    wakeup_monitor_control_reg[`SSM_SEL_HI:`SSM_SEL_LO];
  assign preamble_monitor_select =
    preamble_monitor_control_reg[`SSM_SEL_HI:`SSM_SEL_LO];
  assign preamble_timeout_enable =
    preamble_monitor_control_reg[`SSM_PRE_TMO_BIT];
  assign preamble_error_accumulate =
    preamble_monitor_control_reg[`SSM_PRE_ACC_BIT];

  // disabled monitors are masked out before any decision sees them
  assign wake_fail = mon_fail & wakeup_monitor_select;
  assign passed_next = passed_reg | (mon_pass & wakeup_monitor_select);
  assign all_passed = ((passed_next & wakeup_monitor_select) ==
                       wakeup_monitor_select);
  assign any_failed = |wake_fail;
  // wakeup-phase fails must not leak into the preamble indicators
  assign pre_fail = (phase_preamble && !phase_wakeup) ?
                    (mon_fail & preamble_monitor_select) : 6'h00;

  // one timer serves both phases; preamble start reloads it
  assign timer_restart = wakeup_start | preamble_start;
  assign timer_run = (state_reg == ST_SEARCH) ||
                     (pre_active_reg && preamble_timeout_enable);

  ssm_timeout u_timeout (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(timer_restart),
    .run(timer_run),
    .bit_tick(bit_tick),
    .tmo_count(wakeup_timeout_register_reg[`SSM_TMO_CNT_HI:`SSM_TMO_CNT_LO]),
    .tmo_presc(wakeup_timeout_register_reg[`SSM_TMO_PRESC_HI:
                                           `SSM_TMO_PRESC_LO]),
    .expired(timer_expired)
  );

  // bit order of the select fields maps straight to the monitor index:
  // mon[5] timeout, [4] timing, [3] coding, [2] baud, [1] level, [0] ampl
  always @* begin
    coding_next = `SSM_CODE_ANY;
    enable_next = 6'h00;
    if (phase_wakeup) begin
      coding_next = wakeup_coding_rule;
      enable_next = wakeup_monitor_select;
    end else if (phase_preamble) begin
      coding_next = preamble_coding_rule ? `SSM_CODE_MANCH
                                         : `SSM_CODE_ANY;
      enable_next = preamble_monitor_select;
    end else if (phase_data) begin
      coding_next = data_coding_rule ? `SSM_CODE_MANCH
                                     : `SSM_CODE_ANY;
    end
  end

  always @* begin
    rdata_next = 8'h00;
    if (reg_rd && bank_ok) begin
      if (reg_addr == `SSM_ADDR_DATA_RX) begin
        rdata_next = data_phase_rx_control_reg;
      end else if (reg_addr == `SSM_ADDR_WAKE_MON) begin
        // bit 0 is fixed at zero
        rdata_next = {wakeup_monitor_control_reg[7:1], 1'b0};
      end else if (reg_addr == `SSM_ADDR_PRE_MON) begin
        rdata_next = preamble_monitor_control_reg;
      end else if (reg_addr == `SSM_ADDR_WAKE_TMO) begin
        rdata_next = wakeup_timeout_register_reg;
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_phase_rx_control_reg <= `SSM_RST_DATA_RX;
      wakeup_monitor_control_reg <= `SSM_RST_WAKE_MON;
      preamble_monitor_control_reg <= `SSM_RST_PRE_MON;
      wakeup_timeout_register_reg <= `SSM_RST_WAKE_TMO;
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_next;
      if (reg_wr && bank_ok) begin
        if (reg_addr == `SSM_ADDR_DATA_RX) begin
          data_phase_rx_control_reg <= reg_wdata;
        end else if (reg_addr == `SSM_ADDR_WAKE_MON) begin
          wakeup_monitor_control_reg <= {reg_wdata[7:1], 1'b0};
        end else if (reg_addr == `SSM_ADDR_PRE_MON) begin
          preamble_monitor_control_reg <= reg_wdata;
        end else if (reg_addr == `SSM_ADDR_WAKE_TMO) begin
          wakeup_timeout_register_reg <= reg_wdata;
        end
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coding_rule <= `SSM_CODE_ANY;
      mon_enable <= 6'h00;
    end else begin
      coding_rule <= coding_next;
      mon_enable <= enable_next;
    end
  end

  // wakeup search termination
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      passed_reg <= 6'h00;
      wakeup_pass <= 1'b0;
      wakeup_fail <= 1'b0;
    end else begin
      wakeup_pass <= 1'b0;
      wakeup_fail <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (wakeup_start) begin
            state_reg <= ST_SEARCH;
            passed_reg <= 6'h00;
          end
        end
        default: begin
          passed_reg <= passed_next;
          if (!phase_wakeup) begin
            // search abandoned by the phase controller, no verdict
            state_reg <= ST_IDLE;
          end else if (!wakeup_search_policy && any_failed) begin
            wakeup_fail <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (all_passed) begin
            wakeup_pass <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (wakeup_search_policy && timer_expired) begin
            // single monitor fails are ignored in this policy
            wakeup_fail <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // preamble phase timeout and error accumulation
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_active_reg <= 1'b0;
      preamble_timeout <= 1'b0;
      error_flags <= 6'h00;
    end else begin
      if (preamble_start) begin
        pre_active_reg <= 1'b1;
      end else if (!phase_preamble) begin
        pre_active_reg <= 1'b0;
      end
      preamble_timeout <= pre_active_reg && preamble_timeout_enable &&
                          timer_expired;
      if (preamble_error_accumulate) begin
        // a fail arriving with the clear survives it
        error_flags <= pre_fail |
          ((preamble_start || status_read) ? 6'h00 : error_flags);
      end else if (pre_active_reg) begin
        error_flags <= pre_fail;
      end else if (preamble_start || status_read) begin
        error_flags <= 6'h00;
      end
    end
  end
endmodule // ssm_monitor_ctrl

//--- ssm_defines.vh
`ifndef SSM_DEFINES_VH
`define SSM_DEFINES_VH

// register offsets, valid only in bank zero
`define SSM_ADDR_DATA_RX 8'h2d
`define SSM_ADDR_WAKE_MON 8'h2e
`define SSM_ADDR_PRE_MON 8'h2f
`define SSM_ADDR_WAKE_TMO 8'h31
`define SSM_BANK_MON 2'h0

// reset values
`define SSM_RST_DATA_RX 8'h00
`define SSM_RST_WAKE_MON 8'h00
`define SSM_RST_PRE_MON 8'h00
`define SSM_RST_WAKE_TMO 8'h00

// field positions
`define SSM_WAKE_CODE_HI 3
`define SSM_WAKE_CODE_LO 2
`define SSM_PRE_CODE_BIT 1
`define SSM_DATA_CODE_BIT 0
`define SSM_POLICY_BIT 7
`define SSM_SEL_HI 6
`define SSM_SEL_LO 1
`define SSM_PRE_TMO_BIT 7
`define SSM_PRE_ACC_BIT 0
`define SSM_TMO_PRESC_HI 7
`define SSM_TMO_PRESC_LO 6
`define SSM_TMO_CNT_HI 5
`define SSM_TMO_CNT_LO 0

// coding rule encodings
`define SSM_CODE_ANY 2'h0
`define SSM_CODE_SHORT 2'h1
`define SSM_CODE_LONG 2'h2
`define SSM_CODE_MANCH 2'h3

// prescaler selections and their last prescaler counts (bit-period factor minus one)
`define SSM_PRESC_X2 2'h0
`define SSM_PRESC_X4 2'h1
`define SSM_PRESC_X16 2'h2
`define SSM_PRESC_X64 2'h3
`define SSM_FACT_X2 6'h01
`define SSM_FACT_X4 6'h03
`define SSM_FACT_X16 6'h0f
`define SSM_FACT_X64 6'h3f

`endif

//--- ssm_timeout.v
`timescale 1ns/10ps
`include "ssm_defines.vh"

// counts count x (bit period x prescale factor); count zero never expires
module ssm_timeout (
  clk,
  sys_rst,
  restart,
  run,
  bit_tick,
  tmo_count,
  tmo_presc,
  expired
);
  input wire clk;
  input wire sys_rst;
  input wire restart;
  input wire run;
  input wire bit_tick;
  input wire [5:0] tmo_count;
  input wire [1:0] tmo_presc;
  output reg expired;

  reg [5:0] presc_reg;
  reg [5:0] left_reg;
  reg [5:0] fact_last;

  always @* begin
    case (tmo_presc)
      `SSM_PRESC_X2: fact_last = `SSM_FACT_X2;
      `SSM_PRESC_X4: fact_last = `SSM_FACT_X4;
      `SSM_PRESC_X16: fact_last = `SSM_FACT_X16;
      default: fact_last = `SSM_FACT_X64;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_reg <= 6'h00;
      left_reg <= 6'h00;
      expired <= 1'b0;
    end else if (restart) begin
      presc_reg <= 6'h00;
      left_reg <= tmo_count;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (run && bit_tick && left_reg != 6'h00) begin
        if (presc_reg >= fact_last) begin
          presc_reg <= 6'h00;
          left_reg <= left_reg - 6'h01;
          expired <= (left_reg == 6'h01);
        end else begin
          presc_reg <= presc_reg + 6'h01;
        end
      end
    end
  end
endmodule // ssm_timeout

//--- ssm_checker.sv
`timescale 1ns/10ps
module ssm_checker (
  input wire clk,
  input wire sys_rst,
  input wire [1:0] reg_bank,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire phase_wakeup,
  input wire phase_preamble,
  input wire phase_data,
  input wire preamble_start,
  input wire status_read,
  input wire [5:0] mon_fail,
  input wire [1:0] coding_rule,
  input wire [5:0] mon_enable,
  input wire wakeup_pass,
  input wire wakeup_fail,
  input wire preamble_timeout,
  input wire [5:0] error_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_bank_refuse: assert property (reg_rd && reg_bank != 2'h0 |=>
    reg_rdata == 8'h00) else $error("other bank read data");
  a_idle_quiet: assert property (!phase_wakeup && !phase_preamble &&
    !phase_data |=> coding_rule == 2'h0 && mon_enable == 6'h00)
    else $error("settings out of phase");
  a_data_no_mon: assert property (phase_data && !phase_wakeup &&
    !phase_preamble |=> mon_enable == 6'h00) else $error("data monitors");
  a_result_excl: assert property (!(wakeup_pass && wakeup_fail))
    else $error("pass and fail together");
  a_result_pulse: assert property (wakeup_pass || wakeup_fail |=>
    !wakeup_pass && !wakeup_fail) else $error("result too long");
  a_result_phase: assert property (wakeup_pass || wakeup_fail |->
    $past(phase_wakeup)) else $error("result outside search");
  a_tmo_phase: assert property (preamble_timeout |->
    $past(phase_preamble)) else $error("timeout outside preamble");
  a_flags_clear: assert property (phase_preamble && !phase_wakeup &&
    (status_read || preamble_start) && mon_fail == 6'h00 |=>
    error_flags == 6'h00) else $error("flags not cleared");
endmodule // ssm_checker

bind ssm_monitor_ctrl ssm_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_bank(reg_bank), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .phase_wakeup(phase_wakeup), .phase_preamble(phase_preamble),
  .phase_data(phase_data), .preamble_start(preamble_start),
  .status_read(status_read), .mon_fail(mon_fail),
  .coding_rule(coding_rule), .mon_enable(mon_enable),
  .wakeup_pass(wakeup_pass), .wakeup_fail(wakeup_fail),
  .preamble_timeout(preamble_timeout), .error_flags(error_flags));

//--- ssm_host_model.sv
`timescale 1ns/10ps
module ssm_host_model (
  input wire clk,
  output logic [1:0] reg_bank,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [7:0] reg_rdata
);
  initial begin
    reg_bank = 2'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task sel(input [1:0] b);
    reg_bank = b;
  endtask
  // released lines flip so a stale value is never mistaken for a fresh one
  task wr(input [7:0] a, input [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #2;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    // one idle edge so a following call never re-drives a line at once
    @(posedge clk) #2;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #2;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    @(posedge clk) #2;
  endtask
endmodule // ssm_host_model

//--- test_signal_signature_monitor_control.sv
`timescale 1ns/10ps
module test_signal_signature_monitor_control;
  reg clk, sys_rst, ph_w, ph_p, ph_d, w_st, p_st, st_rd, tick;
  reg [5:0] mp, mf;
  reg [7:0] v;
  wire [1:0] bank, cr;
  wire [7:0] ad, wd, rdat;
  wire wr, rd, wp, wf, pt;
  wire [5:0] me, ef;
  integer failures, cmp_count, i, waited;
  ssm_host_model u_host (.clk(clk), .reg_bank(bank), .reg_addr(ad),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));
  ssm_monitor_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .reg_bank(bank),
    .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat), .phase_wakeup(ph_w), .phase_preamble(ph_p),
    .phase_data(ph_d), .wakeup_start(w_st), .preamble_start(p_st),
    .status_read(st_rd), .bit_tick(tick), .mon_pass(mp), .mon_fail(mf),
    .coding_rule(cr), .mon_enable(me), .wakeup_pass(wp),
    .wakeup_fail(wf), .preamble_timeout(pt), .error_flags(ef));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input [7:0] got, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // waits for one of {pass, fail, preamble timeout}; a hang ends the run
  task res(input [2:0] e);
    integer k;
    k = 0;
    do begin
      cyc(1);
      k = k + 1;
    end while ({wp, wf, pt} === 3'b000 && k < 80);
    waited = k;
    chk({wp, wf, pt}, e);
    if ({wp, wf, pt} === 3'b000) print_verdict;
  endtask
  task wstart;
    w_st = 1'b1;
    cyc(1);
    w_st = 1'b0;
  endtask
  initial begin
    failures = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    {ph_w, ph_p, ph_d, w_st, p_st, st_rd, tick} = 7'h00;
    mp = 6'h00;
    mf = 6'h00;
    cyc(10);
    sys_rst = 1'b0;
    for (i = 8'h2d; i <= 8'h31; i = i + 1) begin
      u_host.rd(i, v);
      chk(v, 8'h00);
    end
    u_host.wr(8'h2e, 8'hff);
    u_host.rd(8'h2e, v);
    chk(v, 8'hfe);
    u_host.sel(2'h1);
    u_host.wr(8'h2d, 8'hff);
    u_host.rd(8'h2d, v);
    chk(v, 8'h00);
    u_host.sel(2'h0);
    u_host.rd(8'h2d, v);
    chk(v, 8'h00);
    $display("registers done");
    ph_w = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      u_host.wr(8'h2d, i << 2);
      cyc(1);
      chk(cr, i);
    end
    chk(me, 8'h3f);
    ph_w = 1'b0;
    ph_p = 1'b1;
    u_host.wr(8'h2d, 8'h02);
    u_host.wr(8'h2f, 8'h54);
    cyc(1);
    chk(cr, 8'h03);
    chk(me, 8'h2a);
    ph_p = 1'b0;
    ph_d = 1'b1;
    u_host.wr(8'h2d, 8'h01);
    cyc(1);
    chk(cr, 8'h03);
    ph_d = 1'b0;
    $display("coding done");
    u_host.wr(8'h2e, 8'h06);
    ph_w = 1'b1;
    wstart;
    mf = 6'h04;
    cyc(1);
    mf = 6'h00;
    mp = 6'h01;
    cyc(1);
    chk({wp, wf}, 8'h00);
    mp = 6'h00;
    mf = 6'h02;
    res(3'b010);
    mf = 6'h00;
    wstart;
    mp = 6'h03;
    res(3'b100);
    mp = 6'h00;
    u_host.wr(8'h2e, 8'h86);
    u_host.wr(8'h31, 8'h01);
    wstart;
    mf = 6'h03;
    cyc(2);
    chk({wp, wf}, 8'h00);
    mf = 6'h00;
    tick = 1'b1;
    res(3'b010);
    chk(waited, 8'h03);
    u_host.wr(8'h31, 8'h82);
    wstart;
    res(3'b010);
    chk(waited, 8'h21);
    u_host.wr(8'h31, 8'hc1);
    wstart;
    res(3'b010);
    chk(waited, 8'h41);
    u_host.wr(8'h31, 8'h00);
    wstart;
    cyc(30);
    chk({wp, wf}, 8'h00);
    mp = 6'h03;
    res(3'b100);
    {tick, ph_w, mp} = 8'h00;
    $display("wakeup done");
    u_host.wr(8'h2f, 8'h83);
    u_host.wr(8'h31, 8'h41);
    ph_p = 1'b1;
    p_st = 1'b1;
    cyc(1);
    {p_st, tick} = 2'b01;
    res(3'b001);
    chk(waited, 8'h05);
    tick = 1'b0;
    mf = 6'h01;
    cyc(1);
    mf = 6'h00;
    cyc(2);
    chk(ef, 8'h01);
    st_rd = 1'b1;
    cyc(1);
    st_rd = 1'b0;
    cyc(1);
    chk(ef, 8'h00);
    u_host.wr(8'h2f, 8'h02);
    mf = 6'h01;
    cyc(1);
    mf = 6'h00;
    cyc(2);
    chk(ef, 8'h00);
    $display("preamble done");
    print_verdict;
  end
endmodule // test_signal_signature_monitor_control
